// >>> rtl/mcu_core_control.sv
// system control of the small microcontroller: ports, reset, modes, timer, interrupts
`timescale 1ns/100ps
module mcu_core_control #(
  parameter logic [9:0] PROG_KEY = mcu_ctrl_pkg::PROG_KEY_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rst_pin,
  input wire logic [2:0] np_in,
  output logic [2:0] np_out,
  output logic [2:0] np_oe,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  output logic osc_enable,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [9:0] code_addr,
  output logic [7:0] code_data,
  input wire logic cpu_reti,
  output logic cpu_run,
  output logic cpu_jump,
  output logic [9:0] cpu_jump_addr,
  output logic prog_mode,
  output logic mc_tick
);
  typedef struct packed {
    logic [2:0] np_s1;
    logic [2:0] np_s2;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [2:0] pa_h;
    logic [7:0] pc_s1;
    logic [7:0] pc_s2;
    logic rp_s1;
    logic rp_s2;
    logic phase;
    logic [2:0] mc_cnt;
    logic tick;
    logic [4:0] rst_cnt;
    logic [3:0] key_cnt;
    logic [9:0] key_sh;
    mcu_ctrl_pkg::mode_t mode;
    logic [2:0] np_latch;
    logic [7:0] sp;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] power_control;
    logic [7:0] timer_control;
    logic [7:0] tl;
    logic [7:0] rtl;
    logic [7:0] th;
    logic [7:0] timer_reload_high;
    logic [7:0] pa_latch;
    logic [7:0] ie;
    logic [7:0] pc_latch;
    logic [7:0] program_status_word;
    logic [7:0] acc;
    logic [7:0] mul;
    logic [7:0] rdata;
    logic in_svc;
    logic jump;
    logic [9:0] jump_addr;
    logic [7:0] paddr_lo;
    logic [2:0] paddr_hi;
    logic vps_h;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [2:0] np_out;
    logic [2:0] np_oe;
    logic [7:0] pa_out;
    logic [7:0] pa_oe;
    logic [7:0] pc_out;
    logic [7:0] pc_oe;
    logic osc_on;
    logic run;
    logic prog;
  } state_t;

  state_t q;
  state_t d;
  logic [7:0] code_mem [mcu_ctrl_pkg::CODE_BYTES];
  logic [7:0] mem_q;
  logic [9:0] mem_rd_addr;

  // every special function register to its reset value
  function automatic state_t with_reset(input state_t s);
    state_t r;
    r = s;
    r.np_latch = mcu_ctrl_pkg::RST_NP;
    r.sp = mcu_ctrl_pkg::RST_SP;
    r.data_pointer_low = mcu_ctrl_pkg::RST_DP;
    r.data_pointer_high = mcu_ctrl_pkg::RST_DP;
    r.power_control = mcu_ctrl_pkg::RST_POWER_CONTROL;
    r.timer_control = mcu_ctrl_pkg::RST_TIMER_CONTROL;
    r.tl = mcu_ctrl_pkg::RST_TMR;
    r.rtl = mcu_ctrl_pkg::RST_TMR;
    r.th = mcu_ctrl_pkg::RST_TMR;
    r.timer_reload_high = mcu_ctrl_pkg::RST_TMR;
    r.pa_latch = mcu_ctrl_pkg::RST_PA;
    r.ie = mcu_ctrl_pkg::RST_IE;
    r.pc_latch = mcu_ctrl_pkg::RST_PC;
    r.program_status_word = mcu_ctrl_pkg::RST_PSW;
    r.acc = mcu_ctrl_pkg::RST_ACC;
    r.mul = mcu_ctrl_pkg::RST_MUL;
    r.in_svc = 1'b0;
    // select seen high, so entering programming writes nothing
    r.vps_h = 1'b1;
    r.osc_on = 1'b1;
    return r;
  endfunction

  always_comb begin
    logic live;
    logic t_fall;
    logic a_fall;
    logic b_fall;
    logic pend_a;
    logic pend_t;
    logic pend_b;
    logic vps;
    logic [9:0] key_word;
    live = 1'b0;
    t_fall = 1'b0;
    a_fall = 1'b0;
    b_fall = 1'b0;
    pend_a = 1'b0;
    pend_t = 1'b0;
    pend_b = 1'b0;
    vps = 1'b0;
    key_word = '0;
    d = q;
    d.np_s1 = np_in;
    d.np_s2 = q.np_s1;
    d.pa_s1 = pa_in;
    d.pa_s2 = q.pa_s1;
    d.pa_h = q.pa_s2[7:5];
    d.pc_s1 = pc_in;
    d.pc_s2 = q.pc_s1;
    d.rp_s1 = rst_pin;
    d.rp_s2 = q.rp_s1;
    d.tick = 1'b0;
    d.jump = 1'b0;
    d.mem_we = 1'b0;

    // oscillator stopped in power-down freezes all timing except the reset pin count
    if (q.mode != mcu_ctrl_pkg::M_PDOWN) begin
      d.phase = ~q.phase;
      if (q.phase) begin
        if (q.mc_cnt == mcu_ctrl_pkg::MC_LAST) begin
          d.mc_cnt = '0;
          d.tick = 1'b1;
        end else begin
          d.mc_cnt = q.mc_cnt + 3'h1;
        end
      end
    end

    // consecutive high samples of the reset pin
    if (q.rp_s2) begin
      if (q.rst_cnt != mcu_ctrl_pkg::RST_HOLD_OSC) begin
        d.rst_cnt = q.rst_cnt + 5'h1;
      end
    end else begin
      d.rst_cnt = '0;
    end

    live = (q.mode == mcu_ctrl_pkg::M_RUN) || (q.mode == mcu_ctrl_pkg::M_IDLE);
    t_fall = q.pa_h[2] & ~q.pa_s2[mcu_ctrl_pkg::PIN_TCNT];
    a_fall = q.pa_h[0] & ~q.pa_s2[mcu_ctrl_pkg::PIN_IRQ_A];
    b_fall = q.pa_h[1] & ~q.pa_s2[mcu_ctrl_pkg::PIN_IRQ_B];

    // timer keeps running in idle; write beats count
    if (live && q.timer_control[mcu_ctrl_pkg::TC_RUN] &&
        (q.timer_control[mcu_ctrl_pkg::TC_CNT_SEL] ? t_fall : q.tick)) begin
      if ({q.th, q.tl} == 16'hFFFF) begin
        d.th = q.timer_reload_high;
        d.tl = q.rtl;
      end else begin
        {d.th, d.tl} = {q.th, q.tl} + 16'h0001;
      end
    end

    if (live && sfr_wr) begin
      case (sfr_addr)
        mcu_ctrl_pkg::SFR_NP: d.np_latch = sfr_wdata[2:0];
        mcu_ctrl_pkg::SFR_SP: d.sp = sfr_wdata;
        mcu_ctrl_pkg::SFR_DPL: d.data_pointer_low = sfr_wdata;
        mcu_ctrl_pkg::SFR_DPH: d.data_pointer_high = sfr_wdata;
        mcu_ctrl_pkg::SFR_POWER_CONTROL: begin
          d.power_control = sfr_wdata;
          if (sfr_wdata[mcu_ctrl_pkg::PC_PDOWN]) begin
            d.mode = mcu_ctrl_pkg::M_PDOWN;
          end else if (sfr_wdata[mcu_ctrl_pkg::PC_IDLE]) begin
            d.mode = mcu_ctrl_pkg::M_IDLE;
          end
        end
        mcu_ctrl_pkg::SFR_TIMER_CONTROL: d.timer_control = sfr_wdata;
        mcu_ctrl_pkg::SFR_TL: d.tl = sfr_wdata;
        mcu_ctrl_pkg::SFR_RTL: d.rtl = sfr_wdata;
        mcu_ctrl_pkg::SFR_TH: d.th = sfr_wdata;
        mcu_ctrl_pkg::SFR_RTH: d.timer_reload_high = sfr_wdata;
        mcu_ctrl_pkg::SFR_PA: d.pa_latch = sfr_wdata;
        mcu_ctrl_pkg::SFR_IE: d.ie = sfr_wdata;
        mcu_ctrl_pkg::SFR_PC: d.pc_latch = sfr_wdata;
        mcu_ctrl_pkg::SFR_PSW: d.program_status_word = sfr_wdata;
        mcu_ctrl_pkg::SFR_ACC: d.acc = sfr_wdata;
        mcu_ctrl_pkg::SFR_MUL: d.mul = sfr_wdata;
        default: d.rdata = q.rdata;
      endcase
    end

    if (sfr_rd) begin
      case (sfr_addr)
        mcu_ctrl_pkg::SFR_NP: d.rdata = {5'h00, q.np_s2};
        mcu_ctrl_pkg::SFR_SP: d.rdata = q.sp;
        mcu_ctrl_pkg::SFR_DPL: d.rdata = q.data_pointer_low;
        mcu_ctrl_pkg::SFR_DPH: d.rdata = q.data_pointer_high;
        mcu_ctrl_pkg::SFR_POWER_CONTROL: d.rdata = q.power_control;
        mcu_ctrl_pkg::SFR_TIMER_CONTROL: d.rdata = q.timer_control;
        mcu_ctrl_pkg::SFR_TL: d.rdata = q.tl;
        mcu_ctrl_pkg::SFR_RTL: d.rdata = q.rtl;
        mcu_ctrl_pkg::SFR_TH: d.rdata = q.th;
        mcu_ctrl_pkg::SFR_RTH: d.rdata = q.timer_reload_high;
        mcu_ctrl_pkg::SFR_PA: d.rdata = q.pa_s2;
        mcu_ctrl_pkg::SFR_IE: d.rdata = q.ie;
        mcu_ctrl_pkg::SFR_PC: d.rdata = q.pc_s2;
        mcu_ctrl_pkg::SFR_PSW: d.rdata = q.program_status_word;
        mcu_ctrl_pkg::SFR_ACC: d.rdata = q.acc;
        mcu_ctrl_pkg::SFR_MUL: d.rdata = q.mul;
        default: d.rdata = 8'h00;
      endcase
    end

    // single level: nothing nests until the routine returns
    if (cpu_reti) begin
      d.in_svc = 1'b0;
    end
    pend_a = q.timer_control[mcu_ctrl_pkg::TC_FLAG_A] & q.ie[mcu_ctrl_pkg::IE_EN_A];
    pend_t = q.timer_control[mcu_ctrl_pkg::TC_OVF] & q.ie[mcu_ctrl_pkg::IE_EN_T];
    pend_b = q.timer_control[mcu_ctrl_pkg::TC_FLAG_B] & q.ie[mcu_ctrl_pkg::IE_EN_B];
    if (live && q.ie[mcu_ctrl_pkg::IE_ALL] && !q.in_svc && !q.jump &&
        (pend_a || pend_t || pend_b)) begin
      d.jump = 1'b1;
      d.in_svc = 1'b1;
      d.mode = mcu_ctrl_pkg::M_RUN;
      d.power_control[mcu_ctrl_pkg::PC_IDLE] = 1'b0;
      if (pend_a) begin
        d.jump_addr = mcu_ctrl_pkg::VEC_IRQ_A;
        if (q.timer_control[mcu_ctrl_pkg::TC_IT_A]) begin
          d.timer_control[mcu_ctrl_pkg::TC_FLAG_A] = 1'b0;
        end
      end else if (pend_t) begin
        d.jump_addr = mcu_ctrl_pkg::VEC_TIMER;
        d.timer_control[mcu_ctrl_pkg::TC_OVF] = 1'b0;
      end else begin
        d.jump_addr = mcu_ctrl_pkg::VEC_IRQ_B;
        if (q.timer_control[mcu_ctrl_pkg::TC_IT_B]) begin
          d.timer_control[mcu_ctrl_pkg::TC_FLAG_B] = 1'b0;
        end
      end
    end

    // hardware sets come last so they win over any clear
    if (live) begin
      if (q.timer_control[mcu_ctrl_pkg::TC_RUN] && {q.th, q.tl} == 16'hFFFF &&
          (q.timer_control[mcu_ctrl_pkg::TC_CNT_SEL] ? t_fall : q.tick)) begin
        d.timer_control[mcu_ctrl_pkg::TC_OVF] = 1'b1;
      end
      if (!q.timer_control[mcu_ctrl_pkg::TC_IT_A]) begin
        d.timer_control[mcu_ctrl_pkg::TC_FLAG_A] = ~q.pa_s2[mcu_ctrl_pkg::PIN_IRQ_A];
      end else if (a_fall) begin
        d.timer_control[mcu_ctrl_pkg::TC_FLAG_A] = 1'b1;
      end
      if (!q.timer_control[mcu_ctrl_pkg::TC_IT_B]) begin
        d.timer_control[mcu_ctrl_pkg::TC_FLAG_B] = ~q.pa_s2[mcu_ctrl_pkg::PIN_IRQ_B];
      end else if (b_fall) begin
        d.timer_control[mcu_ctrl_pkg::TC_FLAG_B] = 1'b1;
      end
    end

    vps = q.np_s2[mcu_ctrl_pkg::NP_VPS];
    case (q.mode)
      mcu_ctrl_pkg::M_HOLD: begin
        d = with_reset(d);
        if (!q.rp_s2) begin
          d.mode = mcu_ctrl_pkg::M_KEY;
          d.key_cnt = '0;
        end
      end
      mcu_ctrl_pkg::M_KEY: begin
        // one key bit per oscillator edge, LSB first
        key_word = {q.rp_s2, q.key_sh[9:1]};
        d.key_sh = key_word;
        d.key_cnt = q.key_cnt + 4'h1;
        if (q.key_cnt == mcu_ctrl_pkg::KEY_LAST) begin
          d.key_cnt = '0;
          if (key_word == PROG_KEY) begin
            d.mode = mcu_ctrl_pkg::M_PROG;
          end else begin
            d.mode = mcu_ctrl_pkg::M_RUN;
            d.jump = 1'b1;
            d.jump_addr = mcu_ctrl_pkg::VEC_RESET;
          end
        end
      end
      mcu_ctrl_pkg::M_PROG: begin
        if (q.np_s2[mcu_ctrl_pkg::NP_ABS]) begin
          d.paddr_hi = q.pc_s2[2:0];
        end else begin
          d.paddr_lo = q.pc_s2[7:0];
        end
        d.vps_h = vps;
        // one write per end of program pulse; port a released for the whole pulse
        if (!q.vps_h && vps) begin
          d.mem_we = 1'b1;
          d.mem_wdata = q.pa_s2;
        end
      end
      mcu_ctrl_pkg::M_RUN: d.mode = d.mode;
      mcu_ctrl_pkg::M_IDLE: d.mode = d.mode;
      mcu_ctrl_pkg::M_PDOWN: d.mode = d.mode;
      default: d.mode = mcu_ctrl_pkg::M_KEY;
    endcase

    // pin reset wins over every mode, power-down included
    if (q.rp_s2 && q.rst_cnt == mcu_ctrl_pkg::RST_HOLD_OSC) begin
      d = with_reset(d);
      d.mode = mcu_ctrl_pkg::M_HOLD;
      d.jump = 1'b0;
      d.mem_we = 1'b0;
    end

    // pin drivers: enable only to pull low unless verify
    if (d.mode == mcu_ctrl_pkg::M_PROG) begin
      d.np_oe = 3'h0;
      d.pc_oe = 8'h00;
      d.pa_out = mem_q;
      d.pa_oe = vps ? 8'hFF : 8'h00;
    end else begin
      d.np_oe = ~d.np_latch;
      d.pa_out = 8'h00;
      d.pa_oe = ~d.pa_latch;
      d.pc_oe = ~d.pc_latch;
    end
    d.osc_on = (d.mode != mcu_ctrl_pkg::M_PDOWN);
    d.run = (d.mode == mcu_ctrl_pkg::M_RUN);
    d.prog = (d.mode == mcu_ctrl_pkg::M_PROG);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= with_reset(state_t'('0));
      // pin synchroniser keeps running so the first key bits survive rst
      q.rp_s1 <= rst_pin;
      q.rp_s2 <= q.rp_s1;
    end else begin
      q <= d;
    end
  end

  // ten address bits only, so the array cannot be expanded
  assign mem_rd_addr = (q.mode == mcu_ctrl_pkg::M_PROG) ? {q.paddr_hi[1:0], q.paddr_lo} : code_addr;

  always_ff @(posedge sys_clk) begin
    if (q.mem_we) begin
      code_mem[{q.paddr_hi[1:0], q.paddr_lo}] <= q.mem_wdata;
    end
    mem_q <= code_mem[mem_rd_addr];
  end

  assign np_out = q.np_out;
  assign np_oe = q.np_oe;
  assign pa_out = q.pa_out;
  assign pa_oe = q.pa_oe;
  assign pc_out = q.pc_out;
  assign pc_oe = q.pc_oe;
  assign osc_enable = q.osc_on;
  assign sfr_rdata = q.rdata;
  assign code_data = mem_q;
  assign cpu_run = q.run;
  assign cpu_jump = q.jump;
  assign cpu_jump_addr = q.jump_addr;
  assign prog_mode = q.prog;
  assign mc_tick = q.tick;
endmodule

// >>> inc/mcu_ctrl_pkg.sv
// constants and types for the microcontroller system control block
// Functional notes
// - narrow port: three open-drain pins, latch 1 floats, latch 0 drives low
// - narrow port read returns actual pin levels, never the latch
// - programming: select input 1 gives verify with outputs on, 0 gives program
// - byte select 0 takes low address byte, 1 takes high byte, three bits
// - pull-up port a: eight quasi pins, latch 1 pulled high and usable as input
// - port a outputs addressed code byte in verify, takes write data in program
// - port a bit 5 irq a, bit 6 irq b, bit 7 timer count input
// - pull-up port c: eight quasi pins like port a
// - programming: port c carries ten-bit code address, muxed by byte select
// - reset pin high for 24 oscillator periods resets the device
// - after reset, ten serial bits LSB first on reset pin enter programming
// - internal timing comes from oscillator through a divide-by-two stage
// - idle stops cpu, peripherals run, all registers kept
// - idle ends on enabled interrupt or hardware reset
// - power-down stops oscillator; only hardware reset ends it
// - code memory is 1024 bytes; no external expansion
// - vectors: reset 000, irq a 003, timer 00B, irq b 013
// - one 16-bit timer auto-reloads on overflow; controls in timer control
// - fixed priority: irq a, then timer flag, then irq b
// - timer mode, port two and priority addresses are not implemented
package mcu_ctrl_pkg;
  localparam logic [7:0] SFR_NP = 8'h80;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] SFR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] SFR_TL = 8'h8A;
  localparam logic [7:0] SFR_RTL = 8'h8B;
  localparam logic [7:0] SFR_TH = 8'h8C;
  localparam logic [7:0] SFR_RTH = 8'h8D;
  localparam logic [7:0] SFR_PA = 8'h90;
  localparam logic [7:0] SFR_IE = 8'hA8;
  localparam logic [7:0] SFR_PC = 8'hB0;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam logic [7:0] SFR_MUL = 8'hF0;
  localparam logic [2:0] RST_NP = 3'h7;
  localparam logic [7:0] RST_SP = 8'hFF;
  localparam logic [7:0] RST_DP = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL = 8'hFF;
  localparam logic [7:0] RST_TIMER_CONTROL = 8'hFF;
  localparam logic [7:0] RST_TMR = 8'hFF;
  localparam logic [7:0] RST_PA = 8'hFF;
  localparam logic [7:0] RST_IE = 8'h00;
  localparam logic [7:0] RST_PC = 8'hFF;
  localparam logic [7:0] RST_PSW = 8'hFF;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_MUL = 8'h00;
  localparam int TC_IT_A = 0;
  localparam int TC_FLAG_A = 1;
  localparam int TC_IT_B = 2;
  localparam int TC_FLAG_B = 3;
  localparam int TC_RUN = 4;
  localparam int TC_OVF = 5;
  localparam int TC_CNT_SEL = 6;
  localparam int IE_EN_A = 0;
  localparam int IE_EN_T = 1;
  localparam int IE_EN_B = 2;
  localparam int IE_ALL = 7;
  localparam int PC_IDLE = 0;
  localparam int PC_PDOWN = 1;
  localparam int PIN_IRQ_A = 5;
  localparam int PIN_IRQ_B = 6;
  localparam int PIN_TCNT = 7;
  localparam int NP_ABS = 0;
  localparam int NP_VPS = 1;
  localparam logic [9:0] VEC_RESET = 10'h000;
  localparam logic [9:0] VEC_IRQ_A = 10'h003;
  localparam logic [9:0] VEC_TIMER = 10'h00B;
  localparam logic [9:0] VEC_IRQ_B = 10'h013;
  localparam int MC_OSC_PERIODS = 12;
  localparam int RST_HOLD_MC = 2;
  localparam logic [4:0] RST_HOLD_OSC = 5'(MC_OSC_PERIODS * RST_HOLD_MC);
  localparam logic [2:0] MC_LAST = 3'(MC_OSC_PERIODS / 2 - 1);
  localparam int KEY_BITS = 10;
  localparam logic [3:0] KEY_LAST = 4'(KEY_BITS - 1);
  localparam logic [9:0] PROG_KEY_DEFAULT = 10'h2A5;
  localparam int CODE_BYTES = 1024;
  typedef enum logic [2:0] {M_KEY, M_RUN, M_IDLE, M_PDOWN, M_HOLD, M_PROG} mode_t;
endpackage

// >>> verification/mcu_core_control_sva.sv
// port-level assertions for the system control block
`timescale 1ns/100ps
module mcu_core_control_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rst_pin,
  input wire logic [2:0] np_in,
  input wire logic [2:0] np_out,
  input wire logic [2:0] np_oe,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pc_oe,
  input wire logic osc_enable,
  input wire logic cpu_run,
  input wire logic cpu_jump,
  input wire logic [9:0] cpu_jump_addr,
  input wire logic prog_mode,
  input wire logic mc_tick
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // counts raw high cycles of the reset pin; saturates so it never wraps
  logic [5:0] hold_q;
  logic [5:0] hold_d;
  always_comb begin
    hold_d = rst_pin ? ((hold_q == 6'h3F) ? hold_q : hold_q + 6'h01) : 6'h00;
  end
  always_ff @(posedge sys_clk) begin
    hold_q <= hold_d;
  end
  AST_NP_OPEN_DRAIN: assert property (np_out == 3'h0)
    else $error("narrow port drives a high level");
  AST_HOLD_RESET: assert property (hold_q >= 6'h1C |-> !cpu_run && osc_enable && !prog_mode)
    else $error("long reset pin pulse did not hold the device");
  AST_PDOWN_STOP: assert property (!osc_enable |-> !cpu_run && !cpu_jump)
    else $error("activity while oscillator stopped");
  AST_JUMP_VECTOR: assert property (cpu_jump |-> cpu_jump_addr inside {10'h000, 10'h003, 10'h00B, 10'h013})
    else $error("jump to a non-vector address");
  AST_JUMP_PULSE: assert property (cpu_jump |=> !cpu_jump)
    else $error("jump pulse longer than one cycle");
  AST_VERIFY_OE: assert property ((prog_mode && np_in[1]) [*4] |=> pa_oe == 8'hFF)
    else $error("verify mode without port a output");
  AST_PROGRAM_OE: assert property ((prog_mode && !np_in[1]) [*4] |=> pa_oe == 8'h00)
    else $error("program mode still drives port a");
  AST_PROG_FLOAT: assert property (prog_mode && $past(prog_mode) |-> np_oe == 3'h0 && pc_oe == 8'h00)
    else $error("address pins driven in programming");
  // divider frozen in power-down and left running by the pin hold; both spans are excluded
  AST_TICK_PERIOD: assert property (disable iff (rst || rst_pin || !osc_enable)
    mc_tick |=> !mc_tick [*8] ##1 !mc_tick ##1 !mc_tick ##1 !mc_tick ##1 mc_tick)
    else $error("machine cycle not twelve clocks");
endmodule
bind mcu_core_control mcu_core_control_sva u_sva (.sys_clk, .rst, .rst_pin, .np_in, .np_out, .np_oe, .pa_oe,
  .pc_oe, .osc_enable, .cpu_run, .cpu_jump, .cpu_jump_addr, .prog_mode, .mc_tick);

// >>> verification/port_board.sv
// board model: pull-ups, open-drain pins and programmer drive
`timescale 1ns/100ps
module port_board (
  input wire logic [2:0] np_out,
  input wire logic [2:0] np_oe,
  input wire logic [2:0] np_low,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic pa_en,
  input wire logic [7:0] pa_val,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe,
  input wire logic pc_en,
  input wire logic [7:0] pc_val,
  output logic [2:0] np_in,
  output logic [7:0] pa_in,
  output logic [7:0] pc_in
);
  // pulled up unless the device or the programmer sinks it
  assign np_in = ~((np_oe & ~np_out) | np_low);
  // released pins take the programmer value or the pull-up level, never the last value
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & (pa_en ? pa_val : 8'hFF));
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & (pc_en ? pc_val : 8'hFF));
endmodule

// >>> verification/tb.sv
// self-checking bench for the system control block
`timescale 1ns/100ps
module tb;
  logic sys_clk, rst, rst_pin, sfr_wr, sfr_rd, cpu_reti, osc_enable, cpu_run, cpu_jump, prog_mode, mc_tick;
  logic pa_en, pc_en;
  logic [2:0] np_in, np_out, np_oe, np_low;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pa_in, pa_out, pa_oe, pc_in, pc_out, pc_oe, pa_val, pc_val, code_data;
  logic [9:0] code_addr, cpu_jump_addr;
  int err_count, n_tests, jumps, j0;
  // port addresses read back pin levels; last three are absent
  localparam logic [7:0] RA [19] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hA8,
    8'hD0, 8'hE0, 8'hF0, 8'h80, 8'h90, 8'hB0, 8'h89, 8'hA0, 8'hB8};
  localparam logic [7:0] RE [19] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00,
    8'hFF, 8'h00, 8'h00, 8'h07, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
  mcu_core_control dut (.sys_clk(sys_clk), .rst(rst), .rst_pin(rst_pin), .np_in(np_in), .np_out(np_out),
    .np_oe(np_oe), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
    .osc_enable(osc_enable), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .code_addr(code_addr), .code_data(code_data), .cpu_reti(cpu_reti), .cpu_run(cpu_run),
    .cpu_jump(cpu_jump), .cpu_jump_addr(cpu_jump_addr), .prog_mode(prog_mode), .mc_tick(mc_tick));
  port_board board (.np_out(np_out), .np_oe(np_oe), .np_low(np_low), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_en(pa_en), .pa_val(pa_val), .pc_out(pc_out), .pc_oe(pc_oe), .pc_en(pc_en), .pc_val(pc_val),
    .np_in(np_in), .pa_in(pa_in), .pc_in(pc_in));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (cpu_jump === 1'b1) jumps++;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    chk({2'h0, sfr_rdata}, {2'h0, e});
    cyc(1);
  endtask
  // bounded wait for a dispatch, then its vector
  task automatic wj(input logic [9:0] e);
    for (int i = 0; i < 200 && cpu_jump !== 1'b1; i++) cyc(1);
    chk({9'h0, cpu_jump}, 10'h001);
    chk(cpu_jump_addr, e);
    cyc(1);
  endtask
  task automatic reti();
    cpu_reti = 1'b1;
    cyc(1);
    cpu_reti = 1'b0;
    cyc(1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #800000;
    err_count++;
    results();
  end
  initial begin
    {rst, rst_pin, sfr_wr, sfr_rd, cpu_reti, pa_en, pc_en} = 7'h40;
    {np_low, sfr_addr, sfr_wdata, pa_val, pc_val, code_addr} = '0;
    err_count = 0;
    n_tests = 0;
    jumps = 0;
    cyc(10);
    rst = 1'b0;
    wj(10'h000);
    for (int i = 0; i < 19; i++) rchk(RA[i], RE[i]);
    wr(8'h81, 8'hA5);
    rchk(8'h81, 8'hA5);
    wr(8'h89, 8'h55);
    rchk(8'h89, 8'h00);
    wr(8'h80, 8'h05);
    cyc(2);
    chk({7'h0, np_oe}, 10'h002);
    np_low = 3'h4;
    cyc(4);
    rchk(8'h80, 8'h01);
    np_low = 3'h0;
    wr(8'h90, 8'h0F);
    cyc(2);
    chk({2'h0, pa_oe}, 10'h0F0);
    rchk(8'h90, 8'h0F);
    wr(8'h90, 8'hFF);
    wr(8'hB0, 8'h3C);
    cyc(2);
    chk({2'h0, pc_oe}, 10'h0C3);
    chk({2'h0, pc_out}, 10'h000);
    wr(8'hB0, 8'hFF);
    // timer stopped and flags cleared before enabling, reset leaves them set
    wr(8'h88, 8'h00);
    wr(8'h8D, 8'h12);
    wr(8'h8B, 8'h34);
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'hFF);
    wr(8'hA8, 8'h82);
    wr(8'h88, 8'h10);
    wj(10'h00B);
    rchk(8'h8C, 8'h12);
    wr(8'h88, 8'h05);
    wr(8'hA8, 8'h87);
    pa_en = 1'b1;
    pa_val = 8'h9F;
    cyc(6);
    reti();
    wj(10'h003);
    reti();
    wj(10'h013);
    reti();
    pa_en = 1'b0;
    wr(8'h81, 8'h5A);
    wr(8'h87, 8'h01);
    cyc(2);
    chk({9'h0, cpu_run}, 10'h000);
    rchk(8'h81, 8'h5A);
    pa_val = 8'hDF;
    pa_en = 1'b1;
    wj(10'h003);
    chk({9'h0, cpu_run}, 10'h001);
    reti();
    pa_en = 1'b0;
    cyc(4);
    wr(8'h87, 8'h02);
    cyc(2);
    chk({9'h0, osc_enable}, 10'h000);
    j0 = jumps;
    pa_en = 1'b1;
    cyc(40);
    chk(10'(jumps), 10'(j0));
    rst_pin = 1'b1;
    cyc(30);
    chk({9'h0, osc_enable}, 10'h001);
    rst_pin = 1'b0;
    pa_en = 1'b0;
    wj(10'h000);
    rchk(8'h81, 8'hFF);
    rst = 1'b1;
    cyc(2);
    for (int i = 0; i < 10; i++) begin
      rst_pin = mcu_ctrl_pkg::PROG_KEY_DEFAULT[i];
      if (i == 2) rst = 1'b0;
      cyc(1);
    end
    rst_pin = 1'b0;
    for (int i = 0; i < 30 && prog_mode !== 1'b1; i++) cyc(1);
    chk({9'h0, prog_mode}, 10'h001);
    np_low = 3'h1;
    pc_en = 1'b1;
    pc_val = 8'h34;
    cyc(4);
    np_low = 3'h0;
    pc_val = 8'hFE;
    cyc(4);
    pa_en = 1'b1;
    pa_val = 8'h5A;
    np_low = 3'h2;
    cyc(8);
    chk({2'h0, pa_oe}, 10'h000);
    np_low = 3'h0;
    cyc(8);
    pa_en = 1'b0;
    chk({2'h0, pa_oe}, 10'h0FF);
    chk({2'h0, pa_out}, 10'h05A);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    wj(10'h000);
    code_addr = 10'h234;
    cyc(2);
    chk({2'h0, code_data}, 10'h05A);
    results();
  end
endmodule
